// *** devig_pkg.sv ***
// Constants shared by the DMA event acceptance and completion interrupt gating block.
// Assumes one 100 MHz clock and a synchronous active-low reset in the user.
// What this block does
// - Latched events serviced only when enabled
// - Quick events serviced only when quick-enabled
// - Secondary bit set blocks further event service
// - Static clear with link FFFFh means null set
// - Any quick parameter update triggers that channel
// - Quick trigger on null set flags missed, secondary
// - Peripheral event on null set flags missed, secondary
// - Completion pends only with final/intermediate enable
// - Pending raises interrupt only when enabled
// - Region interrupt needs region enable of code
// - Enable bits changed only via write-one registers; latch bits also set by events, cleared on service
// - Pending bits cleared by write one to clear
// - Overlapping region enables raise every region
`default_nettype none

package devig_pkg;
   localparam int NUM_CH = 32;
   localparam int NUM_QCH = 8;
   localparam int NUM_REGION = 4;
   localparam int CODE_W = 5;
   localparam int CH_W = 5;
   localparam int LINK_W = 16;
   localparam logic [LINK_W-1:0] NULL_LINK = 16'hFFFF;
   localparam logic STATIC_KEEP_OFF = 1'b0;
   localparam logic [NUM_CH-1:0] BITS_RESET = 32'h0000_0000;
   localparam logic [NUM_QCH-1:0] QBITS_RESET = 8'h00;
endpackage : devig_pkg

`default_nettype wire

// *** devig_gate.sv ***
// Event acceptance and completion interrupt gating of one DMA channel controller.
// Assumes all inputs synchronous to clk_sys_in; write strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module devig_gate (
   input wire logic clk_sys_in, // System clock, 100 MHz
   input wire logic reset_n_in, // Synchronous reset, active low
   // Event sources
   input wire logic [devig_pkg::NUM_CH-1:0] periph_evt_in, // Peripheral event pulses
   input wire logic [devig_pkg::NUM_CH-1:0] manual_evt_in, // Software event set pulses
   // Write-one-to-act control strobes
   input wire logic [devig_pkg::NUM_CH-1:0] event_clear_reg_in, // Clear latch bits
   input wire logic [devig_pkg::NUM_CH-1:0] enable_set_reg_in, // Set event enables
   input wire logic [devig_pkg::NUM_CH-1:0] enable_clear_reg_in, // Clear event enables
   input wire logic [devig_pkg::NUM_QCH-1:0] quick_enable_set_in, // Set quick enables
   input wire logic [devig_pkg::NUM_QCH-1:0] quick_enable_clear_in, // Clear quick enables
   input wire logic [devig_pkg::NUM_CH-1:0] secondary_clear_in, // Clear secondary bits
   input wire logic [devig_pkg::NUM_CH-1:0] missed_clear_in, // Clear missed bits
   input wire logic [devig_pkg::NUM_QCH-1:0] quick_secondary_clear_in, // Clear quick secondary
   input wire logic [devig_pkg::NUM_QCH-1:0] quick_missed_clear_in, // Clear quick missed
   input wire logic [devig_pkg::NUM_CH-1:0] irq_enable_set_in, // Set irq enables
   input wire logic [devig_pkg::NUM_CH-1:0] irq_enable_clear_in, // Clear irq enables
   input wire logic [devig_pkg::NUM_CH-1:0] irq_clear_reg_in, // Clear pending bits
   // Parameter memory activity
   input wire logic parameter_memory_wr_in, // Valid set written, pulse
   input wire logic parameter_memory_wr_quick_in, // Write targets a quick channel
   input wire logic [devig_pkg::CH_W-1:0] parameter_memory_wr_ch_in, // Channel written
   input wire logic last_tr_in, // Last transfer request submitted, pulse
   input wire logic last_tr_quick_in, // Submission was a quick channel
   input wire logic [devig_pkg::CH_W-1:0] last_tr_ch_in, // Channel submitted
   input wire logic last_tr_static_in, // Static-keep option of that set
   input wire logic [devig_pkg::LINK_W-1:0] last_tr_link_in, // Link pointer of that set
   // Completion return
   input wire logic cmpl_in, // Completion returned, pulse
   input wire logic cmpl_final_in, // Final completion
   input wire logic cmpl_intermediate_in, // Intermediate completion
   input wire logic final_completion_irq_en_in, // Option word final irq enable
   input wire logic intermediate_completion_irq_en_in, // Option word intermediate irq enable
   input wire logic [devig_pkg::CODE_W-1:0] completion_code_in, // Completion code
   input wire logic [devig_pkg::NUM_REGION-1:0][devig_pkg::NUM_CH-1:0] region_access_enable_in, // Per region
   // Service request
   output var logic start_out, // Transfer start, pulse
   output var logic start_quick_out, // Start is a quick channel
   output var logic [devig_pkg::CH_W-1:0] start_ch_out, // Channel started
   // Status
   output var logic [devig_pkg::NUM_CH-1:0] event_latch_bits_out, // Latched events
   output var logic [devig_pkg::NUM_CH-1:0] event_enable_bits_out, // Event enables
   output var logic [devig_pkg::NUM_QCH-1:0] quick_enable_bits_out, // Quick enables
   output var logic [devig_pkg::NUM_CH-1:0] secondary_event_bits_out, // Secondary bits
   output var logic [devig_pkg::NUM_CH-1:0] missed_event_bits_out, // Missed bits
   output var logic [devig_pkg::NUM_QCH-1:0] quick_secondary_bits_out, // Quick secondary
   output var logic [devig_pkg::NUM_QCH-1:0] quick_missed_bits_out, // Quick missed
   output var logic [devig_pkg::NUM_CH-1:0] irq_enable_bits_out, // Irq enables
   output var logic [devig_pkg::NUM_CH-1:0] irq_pending_bits_out, // Pending completions
   output var logic irq_global_out, // Global completion interrupt
   output var logic [devig_pkg::NUM_REGION-1:0] irq_region_out // Shadow region interrupts
);
   import devig_pkg::*;

   logic [NUM_CH-1:0] null_r;
   logic [NUM_QCH-1:0] qnull_r;
   logic [NUM_QCH-1:0] qlatch_r;
   logic [NUM_CH-1:0] ready;
   logic [NUM_QCH-1:0] qready;
   logic [NUM_CH-1:0] pick_vec;
   logic [NUM_CH-1:0] qpick_vec;
   logic [NUM_CH-1:0] svc;
   logic [NUM_QCH-1:0] qsvc;
   logic [NUM_CH-1:0] per_arrive;
   logic [NUM_CH-1:0] per_err;
   logic [NUM_QCH-1:0] q_trig;
   logic [NUM_QCH-1:0] q_err;
   logic [NUM_CH-1:0] null_load;
   logic [NUM_CH-1:0] null_lift;
   logic [NUM_QCH-1:0] qnull_load;
   logic [NUM_QCH-1:0] qnull_lift;
   logic [NUM_CH-1:0] pend_set;
   logic [NUM_CH-1:0] pend_nxt;
   logic null_term;
   logic [NUM_CH-1:0] irq_en_nxt;
   wire logic [NUM_REGION-1:0] region_nxt;

   // One-hot of the lowest set bit; used for both channel kinds
   function automatic logic [NUM_CH-1:0] lowest_one(input logic [NUM_CH-1:0] v);
      lowest_one = v & (~v + 32'h0000_0001);
   endfunction

   function automatic logic [CH_W-1:0] onehot_index(input logic [NUM_CH-1:0] v);
      onehot_index = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (v[i]) begin
            onehot_index = CH_W'(i);
         end
      end
   endfunction

   // Null set detection on the set that is loaded after the last request
   assign null_term = (last_tr_static_in == STATIC_KEEP_OFF) && (last_tr_link_in == NULL_LINK);
   assign null_load = (last_tr_in && !last_tr_quick_in && null_term) ? (NUM_CH'(1) << last_tr_ch_in) : '0;
   assign null_lift = (parameter_memory_wr_in && !parameter_memory_wr_quick_in) ? (NUM_CH'(1) << parameter_memory_wr_ch_in) : '0;
   assign qnull_load = (last_tr_in && last_tr_quick_in && null_term) ? (NUM_QCH'(1) << last_tr_ch_in) : '0;
   assign qnull_lift = (parameter_memory_wr_in && parameter_memory_wr_quick_in) ? (NUM_QCH'(1) << parameter_memory_wr_ch_in) : '0;

   // Quick channels autotrigger on any set update, the null reload included
   assign q_trig = qnull_load | qnull_lift;
   assign q_err = q_trig & ((qnull_r & ~qnull_lift) | qnull_load);
   assign per_arrive = periph_evt_in | manual_evt_in;
   assign per_err = per_arrive & null_r;

   // Serviceable: latched, enabled, secondary clear; errored channels stay blocked
   assign ready = event_latch_bits_out & event_enable_bits_out & ~secondary_event_bits_out;
   assign qready = qlatch_r & quick_enable_bits_out & ~quick_secondary_bits_out;
   assign pick_vec = lowest_one(ready);
   assign qpick_vec = lowest_one({{(NUM_CH-NUM_QCH){1'b0}}, qready});
   assign svc = pick_vec;
   assign qsvc = (|ready) ? '0 : qpick_vec[NUM_QCH-1:0];

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         null_r <= BITS_RESET;
         qnull_r <= QBITS_RESET;
      end else begin
         null_r <= (null_r & ~null_lift) | null_load;
         qnull_r <= (qnull_r & ~qnull_lift) | qnull_load;
      end
   end

   // Latches: software clear only by write-one; a new event wins over its clear
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         event_latch_bits_out <= BITS_RESET;
         qlatch_r <= QBITS_RESET;
      end else begin
         event_latch_bits_out <= (event_latch_bits_out & ~event_clear_reg_in & ~svc) | (per_arrive & ~null_r);
         qlatch_r <= (qlatch_r & ~qsvc) | (q_trig & ~q_err);
      end
   end

   // Next enable also feeds the interrupt outputs, so an enable
   // write moves the interrupt in the same cycle as the enable bits
   assign irq_en_nxt = (irq_enable_bits_out | irq_enable_set_in) & ~irq_enable_clear_in;

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         event_enable_bits_out <= BITS_RESET;
         quick_enable_bits_out <= QBITS_RESET;
         irq_enable_bits_out <= BITS_RESET;
      end else begin
         event_enable_bits_out <= (event_enable_bits_out | enable_set_reg_in) & ~enable_clear_reg_in;
         quick_enable_bits_out <= (quick_enable_bits_out | quick_enable_set_in) & ~quick_enable_clear_in;
         irq_enable_bits_out <= irq_en_nxt;
      end
   end

   // Error bits; they hold until software clears them, and a new error wins
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         secondary_event_bits_out <= BITS_RESET;
         missed_event_bits_out <= BITS_RESET;
         quick_secondary_bits_out <= QBITS_RESET;
         quick_missed_bits_out <= QBITS_RESET;
      end else begin
         secondary_event_bits_out <= (secondary_event_bits_out & ~secondary_clear_in) | per_err;
         missed_event_bits_out <= (missed_event_bits_out & ~missed_clear_in) | per_err;
         quick_secondary_bits_out <= (quick_secondary_bits_out & ~quick_secondary_clear_in) | q_err;
         quick_missed_bits_out <= (quick_missed_bits_out & ~quick_missed_clear_in) | q_err;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         start_out <= 1'b0;
         start_quick_out <= 1'b0;
         start_ch_out <= '0;
      end else begin
         start_out <= (|svc) || (|qsvc);
         start_quick_out <= !(|svc) && (|qsvc);
         start_ch_out <= (|svc) ? onehot_index(svc) : onehot_index(qpick_vec);
      end
   end

   // Completion pending; a set in the clear cycle wins
   assign pend_set = (cmpl_in && ((cmpl_final_in && final_completion_irq_en_in)
                     || (cmpl_intermediate_in && intermediate_completion_irq_en_in)))
                     ? (NUM_CH'(1) << completion_code_in) : '0;
   assign pend_nxt = (irq_pending_bits_out & ~irq_clear_reg_in) | pend_set;

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         irq_pending_bits_out <= BITS_RESET;
      end else begin
         irq_pending_bits_out <= pend_nxt;
      end
   end

   // Outputs registered from the next pending value; uncleared bits keep the level
   // high, so the interrupt controller sees no new edge until software clears
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         irq_global_out <= 1'b0;
      end else begin
         irq_global_out <= |(pend_nxt & irq_en_nxt);
      end
   end

   // Every region whose mask holds the code sees the same completion
   for (genvar r = 0; r < NUM_REGION; r++) begin : g_region
      assign region_nxt[r] = |(pend_nxt & irq_en_nxt & region_access_enable_in[r]);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         irq_region_out <= '0;
      end else begin
         irq_region_out <= region_nxt;
      end
   end

endmodule // devig_gate

`default_nettype wire

// *** devig_periph.sv ***
// Peripheral event source model facing the gating block.
// Assumes requests come from the bench as one-cycle pulses per channel.
`timescale 1ns/1ps
`default_nettype none
module devig_periph (
   input wire logic clk_sys_in, // System clock
   input wire logic [31:0] req_in, // Events to emit
   output var logic [31:0] evt_out // One-cycle event pulses
);
   // One register stage, as a real source never answers in the same cycle
   always_ff @(posedge clk_sys_in) begin
      evt_out <= req_in;
   end
endmodule // devig_periph
`default_nettype wire

// *** devig_gate_assertions.sv ***
// Port-level checks of event service and completion interrupt gating.
// Bound to devig_gate; one clock domain, region masks held steady by the user.
`timescale 1ns/1ps
`default_nettype none
module devig_checker (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic start_out,
   input wire logic start_quick_out,
   input wire logic [4:0] start_ch_out,
   input wire logic [31:0] event_enable_bits_out,
   input wire logic [31:0] secondary_event_bits_out,
   input wire logic irq_global_out,
   input wire logic [31:0] irq_pending_bits_out,
   input wire logic [31:0] irq_enable_bits_out,
   input wire logic [3:0] irq_region_out,
   input wire logic [3:0][31:0] region_access_enable_in,
   input wire logic cmpl_in,
   input wire logic cmpl_final_in,
   input wire logic cmpl_intermediate_in,
   input wire logic final_completion_irq_en_in,
   input wire logic intermediate_completion_irq_en_in,
   input wire logic [4:0] completion_code_in,
   input wire logic [31:0] irq_clear_reg_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   a_start_needs_enable: assert property (start_out && !start_quick_out |->
      ($past(event_enable_bits_out) & (32'h0000_0001 << start_ch_out)) != 32'h0000_0000) else $error("bad start");
   a_start_no_secondary: assert property (start_out && !start_quick_out |->
      ($past(secondary_event_bits_out) & (32'h0000_0001 << start_ch_out)) == 32'h0000_0000) else $error("blocked start");
   a_irq_follows_pend: assert property (irq_global_out == |(irq_pending_bits_out & irq_enable_bits_out))
      else $error("global irq wrong");
   a_region_one_gate: assert property (irq_region_out[1] ==
      |(irq_pending_bits_out & irq_enable_bits_out & region_access_enable_in[1])) else $error("region 1 wrong");
   a_region_two_gate: assert property (irq_region_out[2] ==
      |(irq_pending_bits_out & irq_enable_bits_out & region_access_enable_in[2])) else $error("region 2 wrong");
   a_region_needs_pend: assert property (irq_pending_bits_out == 32'h0000_0000 |-> irq_region_out == 4'h0)
      else $error("region irq idle");
   a_pend_needs_option: assert property (!(cmpl_in && (cmpl_final_in && final_completion_irq_en_in ||
      cmpl_intermediate_in && intermediate_completion_irq_en_in)) |=>
      irq_pending_bits_out == ($past(irq_pending_bits_out) & ~$past(irq_clear_reg_in))) else $error("pend changed");
   a_pend_sets_code: assert property (cmpl_in && cmpl_final_in && final_completion_irq_en_in |=>
      irq_pending_bits_out[$past(completion_code_in)]) else $error("pend not set");
   c_dma_start: cover property (start_out && !start_quick_out);
   c_quick_start: cover property (start_out && start_quick_out);
   c_irq: cover property (irq_global_out && irq_region_out[2]);
endmodule // devig_checker
bind devig_gate devig_checker u_chk (.*);
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: strobes by non-blocking assignment at the rising edge.
// Peripheral events pass through devig_periph, one cycle later than requested.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys_in, reset_n_in, parameter_memory_wr_in, parameter_memory_wr_quick_in, last_tr_in, last_tr_quick_in, last_tr_static_in;
   logic cmpl_in, cmpl_final_in, cmpl_intermediate_in, final_completion_irq_en_in, intermediate_completion_irq_en_in;
   logic start_out, start_quick_out, irq_global_out;
   logic [4:0] parameter_memory_wr_ch_in, last_tr_ch_in, completion_code_in, start_ch_out;
   logic [15:0] last_tr_link_in;
   logic [3:0] irq_region_out;
   logic [3:0][31:0] region_access_enable_in;
   logic [7:0] quick_enable_set_in, quick_enable_clear_in, quick_secondary_clear_in, quick_missed_clear_in,
      quick_enable_bits_out, quick_secondary_bits_out, quick_missed_bits_out;
   logic [31:0] pe_req, periph_evt_in, manual_evt_in, event_clear_reg_in, enable_set_reg_in, enable_clear_reg_in,
      secondary_clear_in, missed_clear_in, irq_enable_set_in, irq_enable_clear_in, irq_clear_reg_in,
      event_latch_bits_out, event_enable_bits_out, secondary_event_bits_out, missed_event_bits_out,
      irq_enable_bits_out, irq_pending_bits_out;
   int failures = 0, checked = 0, nst = 0;
   logic [5:0] lst;
   devig_gate uut (.*);
   devig_periph peer (.clk_sys_in(clk_sys_in), .req_in(pe_req), .evt_out(periph_evt_in));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // Counting starts avoids guessing the exact cycle of each pulse
   always @(posedge clk_sys_in) begin
      if (start_out === 1'b1) begin
         nst++;
         lst = {start_quick_out, start_ch_out};
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic quiet;
      {manual_evt_in, event_clear_reg_in, enable_set_reg_in, enable_clear_reg_in, secondary_clear_in} <= '0;
      {missed_clear_in, irq_enable_set_in, irq_enable_clear_in, irq_clear_reg_in, pe_req} <= '0;
      {quick_enable_set_in, quick_enable_clear_in, quick_secondary_clear_in, quick_missed_clear_in} <= '0;
      {parameter_memory_wr_in, parameter_memory_wr_quick_in, parameter_memory_wr_ch_in, last_tr_in, last_tr_quick_in, last_tr_ch_in} <= '0;
      {last_tr_static_in, last_tr_link_in, cmpl_in, cmpl_final_in, cmpl_intermediate_in, completion_code_in} <= '0;
      {final_completion_irq_en_in, intermediate_completion_irq_en_in} <= '0;
   endtask
   task automatic hit(input int n);
      @(posedge clk_sys_in);
      quiet;
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #5us;
      failures++;
      results;
   end
   initial begin
      reset_n_in <= 1'b0;
      region_access_enable_in <= {32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 32'h0000_0001};
      quiet;
      repeat (8) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      hit(0);
      chk("reset", event_latch_bits_out | event_enable_bits_out | irq_pending_bits_out, 32'h0);
      @(posedge clk_sys_in) manual_evt_in <= 32'h0000_0018;
      hit(3);
      chk("starts", nst, 0);
      @(posedge clk_sys_in) enable_set_reg_in <= 32'h0000_0008;
      hit(4);
      chk("chan", lst, 6'h03);
      chk("latch", event_latch_bits_out, 32'h0000_0010);
      @(posedge clk_sys_in) event_clear_reg_in <= 32'h0000_0010;
      @(posedge clk_sys_in) enable_clear_reg_in <= 32'h0000_0008;
      hit(0);
      chk("clr", event_latch_bits_out | event_enable_bits_out, 32'h0);
      $display("test event enable done");
      @(posedge clk_sys_in) begin
         last_tr_in <= 1'b1;
         last_tr_ch_in <= 5'h05;
         last_tr_link_in <= 16'hFFFF;
         enable_set_reg_in <= 32'h0000_0060;
         pe_req <= 32'h0000_0020;
      end
      hit(3);
      chk("err", secondary_event_bits_out & missed_event_bits_out, 32'h0000_0020);
      @(posedge clk_sys_in) begin
         parameter_memory_wr_in <= 1'b1;
         parameter_memory_wr_ch_in <= 5'h05;
         pe_req <= 32'h0000_0020;
      end
      hit(3);
      chk("starts", nst, 1);
      @(posedge clk_sys_in) begin
         secondary_clear_in <= 32'h0000_0020;
         missed_clear_in <= 32'h0000_0020;
      end
      hit(3);
      chk("starts", nst, 2);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys_in) begin
            last_tr_in <= 1'b1;
            last_tr_ch_in <= 5'h06;
            last_tr_static_in <= i[0];
            last_tr_link_in <= i[0] ? 16'hFFFF : 16'h0040;
            pe_req <= 32'h0000_0040;
         end
         hit(3);
         chk("starts", nst, 3 + i);
      end
      $display("test null set done");
      @(posedge clk_sys_in) quick_enable_set_in <= 8'h04;
      @(posedge clk_sys_in) begin
         parameter_memory_wr_in <= 1'b1;
         parameter_memory_wr_quick_in <= 1'b1;
         parameter_memory_wr_ch_in <= 5'h02;
      end
      hit(3);
      chk("quick", lst, 6'h22);
      @(posedge clk_sys_in) begin
         last_tr_in <= 1'b1;
         last_tr_quick_in <= 1'b1;
         last_tr_ch_in <= 5'h02;
         last_tr_link_in <= 16'hFFFF;
      end
      hit(3);
      chk("qerr", {quick_secondary_bits_out, quick_missed_bits_out}, 32'h0404);
      chk("starts", nst, 5);
      @(posedge clk_sys_in) begin
         quick_secondary_clear_in <= 8'h04;
         quick_missed_clear_in <= 8'h04;
         quick_enable_clear_in <= 8'h04;
      end
      @(posedge clk_sys_in) begin
         parameter_memory_wr_in <= 1'b1;
         parameter_memory_wr_quick_in <= 1'b1;
         parameter_memory_wr_ch_in <= 5'h02;
      end
      hit(3);
      chk("starts", nst, 5);
      chk("qbits", {quick_secondary_bits_out, quick_missed_bits_out, quick_enable_bits_out}, 32'h0);
      $display("test quick channel done");
      @(posedge clk_sys_in) begin
         irq_enable_set_in <= 32'h8000_0000;
         cmpl_in <= 1'b1;
         cmpl_final_in <= 1'b1;
         completion_code_in <= 5'h1F;
      end
      hit(1);
      chk("pend", irq_pending_bits_out, 32'h0);
      chk("ien", irq_enable_bits_out, 32'h8000_0000);
      @(posedge clk_sys_in) begin
         cmpl_in <= 1'b1;
         cmpl_final_in <= 1'b1;
         final_completion_irq_en_in <= 1'b1;
         completion_code_in <= 5'h1F;
      end
      hit(0);
      chk("irq", {irq_pending_bits_out[31], irq_global_out, irq_region_out}, 6'h36);
      @(posedge clk_sys_in) irq_clear_reg_in <= 32'h8000_0000;
      hit(0);
      chk("irq", {irq_pending_bits_out[31], irq_global_out, irq_region_out}, 6'h00);
      @(posedge clk_sys_in) begin
         cmpl_in <= 1'b1;
         cmpl_intermediate_in <= 1'b1;
         intermediate_completion_irq_en_in <= 1'b1;
      end
      hit(0);
      chk("irq", {irq_pending_bits_out[0], irq_global_out, irq_region_out}, 6'h20);
      @(posedge clk_sys_in) irq_enable_set_in <= 32'h0000_0001;
      hit(0);
      chk("late en", {irq_enable_bits_out[0], irq_global_out, irq_region_out}, 6'h31);
      @(posedge clk_sys_in) irq_enable_clear_in <= 32'h0000_0001;
      hit(0);
      chk("en clr", {irq_enable_bits_out[0], irq_global_out, irq_region_out}, 6'h00);
      $display("test completion irq done");
      results;
   end
endmodule // testbench
`default_nettype wire
